// ==== core/aes3_subframe_formatter.sv ====
// Subframe framer and deframer for the two-channel serial audio link.
`timescale 1ns/1ps
module aes3_subframe_formatter (
    // Clock and synchronous active-low reset.
    input wire logic CLOCK,
    input wire logic RSTN,
    // Word length shared by both directions, 16 to 24.
    input wire logic [4:0] WORD_LEN,
    // Transmit frame source, channel A.
    input wire logic TX_VALID,
    output logic TX_READY,
    input wire logic [23:0] TX_SAMPLE_A,
    input wire logic [3:0] TX_AUX_A,
    input wire logic TX_V_A,
    input wire logic TX_U_A,
    input wire logic TX_C_A,
    // Transmit frame source, channel B.
    input wire logic [23:0] TX_SAMPLE_B,
    input wire logic [3:0] TX_AUX_B,
    input wire logic TX_V_B,
    input wire logic TX_U_B,
    input wire logic TX_C_B,
    // Transmit line and status.
    output logic TX_LINE,
    output logic TX_ACTIVE,
    output logic TX_BLOCK_START,
    // Receive line.
    input wire logic RX_LINE,
    // Received subframe.
    output logic RX_VALID,
    output logic RX_CHANNEL_B,
    output logic RX_BLOCK_START,
    output logic [23:0] RX_AUDIO,
    output logic [3:0] RX_AUX,
    output logic RX_V,
    output logic RX_U,
    output logic RX_C,
    output logic RX_PARITY_ERR
);

    frame_if fill_if ();
    frame_if drain_if ();

    logic [2:0] div_cnt;
    aes3_pkg::tx_state_t tx_state;
    aes3_pkg::tx_state_t next_tx_state;
    logic [5:0] hc;
    logic [5:0] next_hc;
    logic chan_b;
    logic next_chan_b;
    logic [7:0] frame_idx;
    logic [aes3_pkg::FRAME_W-1:0] frame;
    logic tx_line;
    logic next_line;
    logic pre_inv;
    logic block_pulse;
    logic [7:0] rx_hist;
    logic rx_busy;
    logic [5:0] rx_cnt;
    logic [27:0] rx_word;
    logic rx_is_b;
    logic rx_is_z;
    logic rx_valid;
    logic rx_chan;
    logic rx_block;
    logic [23:0] rx_audio;
    logic [3:0] rx_aux;
    logic [2:0] rx_flags;
    logic rx_perr;

    // Both channels of a frame enter the buffer together, on one rate.
    assign fill_if.valid = TX_VALID;
    assign fill_if.data = {TX_C_B, TX_U_B, TX_V_B, TX_AUX_B, TX_SAMPLE_B,
                           TX_C_A, TX_U_A, TX_V_A, TX_AUX_A, TX_SAMPLE_A};
    assign TX_READY = fill_if.ready;

    frame_buffer u_buffer (
        .clock(CLOCK),
        .rstn(RSTN),
        .fill(fill_if.snk),
        .drain(drain_if.src)
    );

    // One half-cell enable serves both directions, so they share one rate.
    wire tick = (div_cnt == aes3_pkg::HALF_DIV_LAST);

    // Half-cell rate divider.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
        end
    end

    // Word length is clamped so that odd settings still give a legal map.
    wire [4:0] len_c = (WORD_LEN < aes3_pkg::LEN_MIN) ? aes3_pkg::LEN_MIN :
                       (WORD_LEN > aes3_pkg::LEN_MAX) ? aes3_pkg::LEN_MAX :
                       WORD_LEN;
    wire mode20 = (len_c <= aes3_pkg::LEN_MODE20);
    wire [4:0] sh24 = aes3_pkg::LEN_MAX - len_c;
    wire [4:0] sh20 = aes3_pkg::LEN_MODE20 - len_c;

    // Channel entry for the subframe now on the line.
    wire [aes3_pkg::CH_W-1:0] sel = chan_b ?
        frame[aes3_pkg::FRAME_W-1:aes3_pkg::F_CH_B_LSB] :
        frame[aes3_pkg::CH_W-1:0];

    // Samples are right-justified; the shift fills unused LSBs with zero.
    // Codes pass without any sign change, so positive stays positive.
    wire [23:0] s24 = sel[23:0] << sh24;
    wire [19:0] s20 = sel[19:0] << sh20;
    wire [3:0] aux = sel[aes3_pkg::F_AUX_LSB+3:aes3_pkg::F_AUX_LSB];
    wire [23:0] audio = mode20 ? {s20, aux} : s24;

    // Slots 4 to 30 then parity; the preamble takes no part in the sum.
    wire [26:0] payload = {sel[aes3_pkg::F_C],
                           sel[aes3_pkg::F_U],
                           sel[aes3_pkg::F_V],
                           audio};
    wire [27:0] slot_word = {^payload, payload};

    // Data slot index and the bit it carries.
    wire [4:0] dslot = hc[5:1] - aes3_pkg::FIRST_DATA_SLOT;
    wire tx_bit = slot_word[dslot];

    // Preamble choice: Z opens a block, X other A subframes, Y for B.
    wire [7:0] pre_pat = chan_b ? aes3_pkg::PRE_Y :
                         (frame_idx == aes3_pkg::FRAME_RESET) ?
                         aes3_pkg::PRE_Z : aes3_pkg::PRE_X;
    wire [2:0] pre_pos = 3'h7 - hc[2:0];
    wire pre_ref = (hc == 6'h00) ? tx_line : pre_inv;
    wire in_pre = (hc <= aes3_pkg::HC_PRE_LAST);
    wire sub_end = (hc == aes3_pkg::HC_LAST);

    // Frame counter wraps every block.
    wire [7:0] frame_next = (frame_idx == aes3_pkg::FRAME_LAST) ?
                            aes3_pkg::FRAME_RESET : frame_idx + 8'h01;

    // A frame is taken only at a frame boundary, so pairs never split.
    wire idle = (tx_state == aes3_pkg::TX_IDLE);
    wire load_slot = tick && (idle || (sub_end && chan_b));
    wire load = load_slot && drain_if.valid;
    wire [7:0] load_idx = idle ? frame_idx : frame_next;
    assign drain_if.ready = load_slot;

    // Line level of the half-cell emitted at the next tick.
    // The preamble follows the previous level, so it may appear inverted.
    always_comb begin
        next_line = tx_line;
        if (!idle) begin
            if (in_pre) begin
                next_line = pre_pat[pre_pos] ^ pre_ref;
            end else if (!hc[0]) begin
                next_line = ~tx_line;
            end else begin
                next_line = tx_line ^ tx_bit;
            end
        end
    end

    // Sequencer: half-cells advance in ascending slot order.
    always_comb begin
        next_tx_state = tx_state;
        next_hc = hc;
        next_chan_b = chan_b;
        unique case (tx_state)
            aes3_pkg::TX_IDLE: begin
                if (load) begin
                    next_tx_state = aes3_pkg::TX_PRE;
                    next_hc = 6'h00;
                    next_chan_b = 1'b0;
                end
            end
            aes3_pkg::TX_PRE: begin
                next_hc = hc + 6'h01;
                if (hc == aes3_pkg::HC_PRE_LAST) begin
                    next_tx_state = aes3_pkg::TX_DATA;
                end
            end
            aes3_pkg::TX_DATA: begin
                next_hc = hc + 6'h01;
                if (sub_end && !chan_b) begin
                    next_tx_state = aes3_pkg::TX_PRE;
                    next_chan_b = 1'b1;
                end else if (sub_end && load) begin
                    next_tx_state = aes3_pkg::TX_PRE;
                    next_chan_b = 1'b0;
                end else if (sub_end) begin
                    next_tx_state = aes3_pkg::TX_IDLE;
                    next_chan_b = 1'b0;
                end
            end
            default: begin
                next_tx_state = aes3_pkg::TX_IDLE;
            end
        endcase
    end

    // Transmit state registers, stepped once per half-cell.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            tx_state <= aes3_pkg::TX_IDLE;
            hc <= 6'h00;
            chan_b <= 1'b0;
            tx_line <= aes3_pkg::LINE_RESET;
            pre_inv <= 1'b0;
        end else if (tick) begin
            tx_state <= next_tx_state;
            hc <= next_hc;
            chan_b <= next_chan_b;
            tx_line <= next_line;
            if (hc == 6'h00) begin
                pre_inv <= tx_line;
            end
        end
    end

    // Frame entry and block position; the index moves at each frame end.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            frame <= '0;
            frame_idx <= aes3_pkg::FRAME_RESET;
            block_pulse <= 1'b0;
        end else begin
            block_pulse <= load && (load_idx == aes3_pkg::FRAME_RESET);
            if (load) begin
                frame <= drain_if.data;
            end
            if (tick && !idle && sub_end && chan_b) begin
                frame_idx <= frame_next;
            end
        end
    end

    // Transmit outputs; the block pulse lets the source align status bits.
    assign TX_LINE = tx_line;
    assign TX_ACTIVE = !idle;
    assign TX_BLOCK_START = block_pulse;

    // Receive history, newest half-cell in bit 0.
    wire [7:0] hist_next = {rx_hist[6:0], RX_LINE};
    wire is_x = (hist_next == aes3_pkg::PRE_X) ||
                (hist_next == ~aes3_pkg::PRE_X);
    wire is_y = (hist_next == aes3_pkg::PRE_Y) ||
                (hist_next == ~aes3_pkg::PRE_Y);
    wire is_z = (hist_next == aes3_pkg::PRE_Z) ||
                (hist_next == ~aes3_pkg::PRE_Z);
    // A real preamble always opens with a transition from the level before
    // it. Without this test, a block preamble sent after an idle line shows
    // an inverted X pattern three half-cells early, and the frame is lost.
    wire opens = rx_hist[7] ^ rx_hist[6];
    wire is_pre = (is_x || is_y || is_z) && opens;

    // A data slot is one when its two halves differ.
    wire rx_bit = rx_hist[0] ^ RX_LINE;
    wire [27:0] word_next = {rx_bit, rx_word[27:1]};
    wire rx_done = tick && rx_busy && (rx_cnt == aes3_pkg::RX_HALVES_LAST);

    // Hunting stops while a subframe is decoded, so data never fakes a sync.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            rx_hist <= 8'h00;
            rx_busy <= 1'b0;
            rx_cnt <= 6'h00;
            rx_word <= 28'h000_0000;
            rx_is_b <= 1'b0;
            rx_is_z <= 1'b0;
        end else if (tick) begin
            rx_hist <= hist_next;
            if (!rx_busy) begin
                if (is_pre) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= 6'h00;
                    rx_is_b <= is_y;
                    rx_is_z <= is_z;
                end
            end else begin
                rx_cnt <= rx_cnt + 6'h01;
                if (rx_cnt[0]) begin
                    rx_word <= word_next;
                end
                if (rx_cnt == aes3_pkg::RX_HALVES_LAST) begin
                    rx_busy <= 1'b0;
                end
            end
        end
    end

    // Received subframe fields; the receiver does not mask by word length.
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            rx_valid <= 1'b0;
            rx_chan <= 1'b0;
            rx_block <= 1'b0;
            rx_audio <= 24'h00_0000;
            rx_aux <= 4'h0;
            rx_flags <= 3'h0;
            rx_perr <= 1'b0;
        end else begin
            rx_valid <= rx_done;
            if (rx_done) begin
                rx_chan <= rx_is_b;
                rx_block <= rx_is_z;
                rx_audio <= mode20 ? {word_next[23:4], 4'h0} :
                            word_next[23:0];
                rx_aux <= mode20 ? word_next[3:0] : 4'h0;
                rx_flags <= word_next[26:24];
                rx_perr <= ^word_next;
            end
        end
    end

    // Receive outputs.
    assign RX_VALID = rx_valid;
    assign RX_CHANNEL_B = rx_chan;
    assign RX_BLOCK_START = rx_block;
    assign RX_AUDIO = rx_audio;
    assign RX_AUX = rx_aux;
    assign RX_V = rx_flags[0];
    assign RX_U = rx_flags[1];
    assign RX_C = rx_flags[2];
    assign RX_PARITY_ERR = rx_perr;

endmodule

// ==== core/aes3_pkg.sv ====
// Constants, field layout and state encoding of the audio subframe formatter.
package aes3_pkg;

    // Widths of one channel entry and of a whole frame entry.
    localparam int AUDIO_W = 24;
    localparam int AUX_W = 4;
    localparam int CH_W = 31;
    localparam int FRAME_W = 62;
    localparam int DATA_W = 28;

    // Field positions inside one channel entry, and where channel B starts in a frame entry.
    localparam int F_AUX_LSB = 24;
    localparam int F_V = 28;
    localparam int F_U = 29;
    localparam int F_C = 30;
    localparam int F_CH_B_LSB = 31;

    // Word length limits and the 20-bit range boundary.
    localparam logic [4:0] LEN_MIN = 5'h10;
    localparam logic [4:0] LEN_MAX = 5'h18;
    localparam logic [4:0] LEN_MODE20 = 5'h14;

    // Preamble patterns in half-cells, sent after a low line level.
    localparam logic [7:0] PRE_X = 8'he2;
    localparam logic [7:0] PRE_Y = 8'he4;
    localparam logic [7:0] PRE_Z = 8'he8;

    // Half-cell positions inside one subframe of 64 half-cells.
    localparam logic [5:0] HC_PRE_LAST = 6'h07;
    localparam logic [5:0] HC_LAST = 6'h3f;
    localparam logic [4:0] FIRST_DATA_SLOT = 5'h04;
    localparam logic [5:0] RX_HALVES_LAST = 6'h37;

    // Frames per block and the half-cell rate divider.
    localparam logic [7:0] FRAME_LAST = 8'hbf;
    localparam logic [2:0] HALF_DIV_LAST = 3'h3;

    // Values after reset.
    localparam logic LINE_RESET = 1'b0;
    localparam logic [7:0] FRAME_RESET = 8'h00;

    // Transmit sequencer, Gray coded along idle, preamble, data.
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_PRE = 2'h1,
        TX_DATA = 2'h3
    } tx_state_t;

endpackage

// ==== core/frame_if.sv ====
// Valid and ready channel that carries one frame entry between modules.
`timescale 1ns/1ps
interface frame_if;
    logic valid;
    logic ready;
    logic [aes3_pkg::FRAME_W-1:0] data;

    // The source drives valid and data; the sink drives ready.
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== core/frame_buffer.sv ====
// Two-entry frame buffer with valid and ready on both sides.
`timescale 1ns/1ps
module frame_buffer (
    // Clock and synchronous active-low reset.
    input wire logic clock,
    input wire logic rstn,
    // Filling side and draining side.
    frame_if.snk fill,
    frame_if.src drain
);

    logic [aes3_pkg::FRAME_W-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic [1:0] next_count;

    // Handshakes; two entries let the source run a frame ahead of the line.
    wire push = fill.valid && fill.ready;
    wire pop = drain.valid && drain.ready;
    assign fill.ready = (count != 2'h2);
    assign drain.valid = (count != 2'h0);
    assign drain.data = mem[rd_ptr];

    // Occupancy follows the two handshakes of the cycle.
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count <= next_count;
        end
    end

    // Each entry is written only when the write pointer names it.
    for (genvar i = 0; i < 2; i++) begin : g_entry
        always_ff @(posedge clock) begin
            if (!rstn) begin
                mem[i] <= '0;
            end else if (push && (wr_ptr == i)) begin
                mem[i] <= fill.data;
            end
        end
    end

endmodule

// ==== core/aes3_subframe_formatter_end.sv ====
// Spare design file; the formatter and its frame buffer live in their own.
`timescale 1ns/1ps

// ==== tb/aes3_fmt_chk.sv ====
// Port-level assertions for the audio subframe formatter.
`timescale 1ns/1ps
module aes3_fmt_chk (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RSTN,
    // Watched ports.
    input wire logic [4:0] WORD_LEN,
    input wire logic TX_LINE,
    input wire logic TX_ACTIVE,
    input wire logic RX_VALID,
    input wire logic RX_CHANNEL_B,
    input wire logic RX_BLOCK_START,
    input wire logic [23:0] RX_AUDIO,
    input wire logic [3:0] RX_AUX
);
    // A single domain, so clock and reset are declared once.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    // The first preamble half follows one half-cell after activity starts.
    property p_first_half;
        $rose(TX_ACTIVE) |-> $stable(TX_LINE)[*4] ##1 $changed(TX_LINE);
    endproperty
    a_first_half: assert property (p_first_half)
        else $error("Preamble start misplaced.");

    // A half-cell lasts four cycles, so edges are never closer.
    property p_half_cell;
        $changed(TX_LINE) |=> $stable(TX_LINE)[*3];
    endproperty
    a_half_cell: assert property (p_half_cell)
        else $error("Line half-cell shorter than four cycles.");

    // An idle transmitter holds its line level.
    property p_idle_hold;
        !TX_ACTIVE && !$past(TX_ACTIVE) |-> $stable(TX_LINE);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("Line moved while idle.");

    // In the 24-bit range the low slots are audio, not auxiliary bits.
    property p_aux_24;
        RX_VALID && WORD_LEN > aes3_pkg::LEN_MODE20 |-> RX_AUX == 4'h0;
    endproperty
    a_aux_24: assert property (p_aux_24)
        else $error("Auxiliary bits reported in 24-bit range.");

    // In the 20-bit range the audio word starts at slot 8.
    property p_lsb_20;
        RX_VALID && WORD_LEN <= aes3_pkg::LEN_MODE20 |-> RX_AUDIO[3:0] == 4'h0;
    endproperty
    a_lsb_20: assert property (p_lsb_20)
        else $error("Audio below slot 8 in 20-bit range.");

    // Received fields only change together with the valid pulse.
    property p_hold;
        !RX_VALID |-> $stable({RX_AUDIO, RX_AUX});
    endproperty
    a_hold: assert property (p_hold)
        else $error("Received fields changed without a subframe.");

    // The block preamble only ever opens the first channel.
    property p_z_on_a;
        RX_VALID && RX_BLOCK_START |-> !RX_CHANNEL_B;
    endproperty
    a_z_on_a: assert property (p_z_on_a)
        else $error("Block start on second channel.");

    // The second channel follows exactly one subframe of 256 cycles later.
    property p_pair;
        RX_VALID && !RX_CHANNEL_B |-> ##256 (RX_VALID && RX_CHANNEL_B);
    endproperty
    a_pair: assert property (p_pair)
        else $error("Frame not completed by its second subframe.");
endmodule

bind aes3_subframe_formatter aes3_fmt_chk u_chk (
    .CLOCK(CLOCK), .RSTN(RSTN), .WORD_LEN(WORD_LEN), .TX_LINE(TX_LINE),
    .TX_ACTIVE(TX_ACTIVE), .RX_VALID(RX_VALID), .RX_CHANNEL_B(RX_CHANNEL_B),
    .RX_BLOCK_START(RX_BLOCK_START), .RX_AUDIO(RX_AUDIO), .RX_AUX(RX_AUX)
);

// ==== tb/aes3_far_end.sv ====
// Far-end model that echoes the transmit line back to the receiver.
`timescale 1ns/1ps
module aes3_far_end (
    // Line from the block.
    input wire logic line_in,
    // Fault controls from the bench.
    input wire logic invert,
    input wire logic corrupt,
    // Line to the receive input.
    output logic line_out
);
    // Inversion keeps biphase-mark bits intact, so only preambles see it;
    // a corrupt window of four cycles flips exactly one sampled half-cell.
    assign line_out = line_in ^ invert ^ corrupt;
endmodule

// ==== tb/test_aes3_subframe_formatter.sv ====
// Self-checking bench for the subframe formatter, run in line loopback.
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    n_errors++; $display("Error at %0t ns: got %0h expected %0h", \
    $time, (got), (exp)); end end
module test_aes3_subframe_formatter;
    typedef struct packed {
        logic bad;
        logic blk;
        logic chb;
        logic [23:0] audio;
        logic [3:0] aux;
        logic [2:0] vuc;
    } note_t;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic [4:0] WORD_LEN = 5'h18;
    logic TX_VALID = 1'b0;
    logic [23:0] TX_SAMPLE_A = 24'h00_0000, TX_SAMPLE_B = 24'h00_0000;
    logic [3:0] TX_AUX_A = 4'h0, TX_AUX_B = 4'h0;
    logic TX_V_A = 1'b0, TX_U_A = 1'b0, TX_C_A = 1'b0;
    logic TX_V_B = 1'b0, TX_U_B = 1'b0, TX_C_B = 1'b0;
    logic invert = 1'b0, corrupt = 1'b0;
    logic TX_READY, TX_LINE, TX_ACTIVE, TX_BLOCK_START, RX_LINE, RX_VALID;
    logic RX_CHANNEL_B, RX_BLOCK_START, RX_V, RX_U, RX_C, RX_PARITY_ERR;
    logic [23:0] RX_AUDIO;
    logic [3:0] RX_AUX;
    logic [4:0] lens [4] = '{5'h10, 5'h14, 5'h15, 5'h17};
    note_t notes [$];
    note_t exp;
    int seed = 32'h67b0;
    int n_errors = 0, compares = 0, fidx = 0, n_blk = 0;

    always #20 CLOCK = ~CLOCK;

    aes3_subframe_formatter u_dut (
        .CLOCK(CLOCK), .RSTN(RSTN), .WORD_LEN(WORD_LEN),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY),
        .TX_SAMPLE_A(TX_SAMPLE_A), .TX_AUX_A(TX_AUX_A), .TX_V_A(TX_V_A),
        .TX_U_A(TX_U_A), .TX_C_A(TX_C_A), .TX_SAMPLE_B(TX_SAMPLE_B),
        .TX_AUX_B(TX_AUX_B), .TX_V_B(TX_V_B), .TX_U_B(TX_U_B),
        .TX_C_B(TX_C_B), .TX_LINE(TX_LINE), .TX_ACTIVE(TX_ACTIVE),
        .TX_BLOCK_START(TX_BLOCK_START), .RX_LINE(RX_LINE),
        .RX_VALID(RX_VALID), .RX_CHANNEL_B(RX_CHANNEL_B),
        .RX_BLOCK_START(RX_BLOCK_START), .RX_AUDIO(RX_AUDIO),
        .RX_AUX(RX_AUX), .RX_V(RX_V), .RX_U(RX_U), .RX_C(RX_C),
        .RX_PARITY_ERR(RX_PARITY_ERR)
    );

    aes3_far_end u_far (
        .line_in(TX_LINE), .invert(invert), .corrupt(corrupt),
        .line_out(RX_LINE)
    );

    // Expected subframe: unused low slots zero, aux only in 20-bit range.
    function automatic note_t mk(logic bad, logic blk, logic chb,
        logic [23:0] s, logic [3:0] a, logic [2:0] vuc);
        mk = '{bad, blk, chb, s << (24 - WORD_LEN),
            (WORD_LEN <= aes3_pkg::LEN_MODE20) ? a : 4'h0, vuc};
    endfunction

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Offers one random frame and returns just after the clock edge that takes it.
    task automatic send_frame(input logic bad);
        int k;
        TX_SAMPLE_A = 24'($random(seed));
        TX_SAMPLE_B = 24'($random(seed));
        {TX_AUX_A, TX_AUX_B} = 8'($random(seed));
        {TX_V_A, TX_U_A, TX_C_A, TX_V_B, TX_U_B, TX_C_B} = 6'($random(seed));
        TX_VALID = 1'b1;
        notes.push_back(mk(bad, fidx == 0, 1'b0, TX_SAMPLE_A, TX_AUX_A,
            {TX_V_A, TX_U_A, TX_C_A}));
        notes.push_back(mk(1'b0, 1'b0, 1'b1, TX_SAMPLE_B, TX_AUX_B,
            {TX_V_B, TX_U_B, TX_C_B}));
        fidx = (fidx + 1) % 192;
        k = 0;
        while (TX_READY !== 1'b1 && k < 3000) begin
            @(posedge CLOCK);
            #1 k++;
        end
        if (k == 3000) begin
            n_errors++;
            final_report();
        end
        @(posedge CLOCK);
        #1;
    endtask

    // Stops offering and waits until every noted subframe has arrived.
    task automatic drain(input string name);
        int k;
        TX_VALID = 1'b0;
        k = 0;
        while ((notes.size() != 0 || TX_ACTIVE !== 1'b0) && k < 6000) begin
            @(posedge CLOCK);
            #1 k++;
        end
        if (k == 6000) begin
            n_errors++;
            final_report();
        end
        repeat (8) @(posedge CLOCK);
        #1 $display("Test %0s done", name);
    endtask

    // Each decoded subframe is matched against the oldest note.
    always @(negedge CLOCK) begin
        if (TX_BLOCK_START === 1'b1) begin
            n_blk++;
        end
        if (RX_VALID === 1'b1 && notes.size() == 0) begin
            n_errors++;
            $display("Error at %0t ns: got %0h expected %0h", $time,
                RX_AUDIO, 24'h00_0000);
        end else if (RX_VALID === 1'b1) begin
            exp = notes.pop_front();
            `CHECK(RX_PARITY_ERR, exp.bad)
            if (!exp.bad) begin
                `CHECK(RX_BLOCK_START, exp.blk)
                `CHECK(RX_CHANNEL_B, exp.chb)
                `CHECK(RX_AUDIO, exp.audio)
                `CHECK(RX_AUX, exp.aux)
                `CHECK({RX_V, RX_U, RX_C}, exp.vuc)
            end
        end
    end

    initial begin
        repeat (3) @(posedge CLOCK);
        #1 RSTN = 1'b1;
        // Back-to-back frames fill the two-entry buffer until it refuses.
        send_frame(1'b0);
        send_frame(1'b0);
        send_frame(1'b0);
        `CHECK(TX_READY, 1'b0)
        send_frame(1'b0);
        drain("back_to_back");
        // Word lengths on both sides of the 20-bit boundary.
        foreach (lens[i]) begin
            WORD_LEN = lens[i];
            send_frame(1'b0);
            send_frame(1'b0);
            drain("word_length");
        end
        // The far end returns an inverted line; preambles must still lock.
        invert = 1'b1;
        drain("invert_settle");
        send_frame(1'b0);
        send_frame(1'b0);
        drain("inverted_line");
        invert = 1'b0;
        drain("invert_clear");
        // One half-cell in the first subframe's data is flipped.
        send_frame(1'b1);
        TX_VALID = 1'b0;
        repeat (100) @(posedge CLOCK);
        #1 corrupt = 1'b1;
        repeat (4) @(posedge CLOCK);
        #1 corrupt = 1'b0;
        drain("parity_error");
        `CHECK(n_blk, 1)
        final_report();
    end
endmodule
